/* File: core/efsb_pkg.sv */
// Constants and types for the earth fault stage block, event and record logic
//
// How it works
// - The external block input is sampled at each program cycle tick, before stage evaluation.
// - The stage block comes from a dedicated blocking-matrix input, plus optional inrush blocking from the harmonic ratio.
// - Pick-up without blocking asserts start and runs the trip delay timer.
// - Blocking present at pick-up asserts blocked; no start or trip follows.
// - Blocking after start drops start and signals release, as on pick-up dropout.
// - One-bit inrush blocking enable: 0 disabled, 1 enabled, disabled after reset.
// - Enabled inrush blocks when second harmonic ratio exceeds a limit up to 50 percent.
// - Each blocking activation raises a display notification and a stamped blocking event.
// - Start, trip and blocked transitions create events and feed fault recording.
// - A per-event mask selects ON, OFF or both into the main event buffer.
// - Four stages; stage-tagged events incl. resistive and reactive start and trip.
// - Every event carries a time stamp and the measurement values of that moment.
// - Each stage keeps its own history of the twelve latest fault records.
// - Only ON transitions of start, trip or blocked write a fault record.
// - Records hold identity, ms stamp, currents, voltages, angle, remaining time, group, grounding.
// - Stage condition is two bits: 0 normal, 1 started, 2 tripped, 3 blocked.
package efsb_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int EFSB_NUM_STAGES = 4;
  localparam int EFSB_NUM_SIGS = 7;
  localparam int EFSB_NUM_EVT = EFSB_NUM_STAGES * EFSB_NUM_SIGS;
  localparam int EFSB_REC_DEPTH = 12;
  localparam int EFSB_REC_WORDS = 7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int EFSB_CLK_PERIOD_NS = 4;
  localparam int EFSB_MS_NS = 1000000;
  localparam int EFSB_MS_CYCLES = EFSB_MS_NS / EFSB_CLK_PERIOD_NS;
  localparam int EFSB_BLOCK_LEAD_MS = 5;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] EFSB_OFS_CTRL = 8'h00;
  localparam logic [7:0] EFSB_OFS_LIMIT = 8'h04;
  localparam logic [7:0] EFSB_OFS_EVMASK = 8'h08;
  localparam logic [7:0] EFSB_OFS_COND = 8'h0C;
  localparam logic [7:0] EFSB_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] EFSB_OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] EFSB_OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] EFSB_OFS_REC_SEL = 8'h1C;
  localparam logic [7:0] EFSB_OFS_REC_DATA = 8'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int EFSB_EVMASK_OFF_POS = 16;
  localparam int EFSB_COND_BLK_POS = 8;
  localparam int EFSB_SEL_AGE_POS = 8;
  localparam int EFSB_SEL_CNT_POS = 16;
  localparam logic EFSB_INRUSH_EN_RST = 1'b0;
  localparam logic [12:0] EFSB_LIMIT_RST = 13'h0001;
  localparam logic [12:0] EFSB_LIMIT_MAX = 13'h1388;
  localparam logic [13:0] EFSB_EVMASK_RST = 14'h3FFF;
  localparam logic [11:0] EFSB_IRQ_EN_RST = 12'h000;

  // Stage state, code equals reported condition
  typedef enum logic [1:0] {
    EFSB_ST_NORMAL = 2'b00,
    EFSB_ST_START = 2'b01,
    EFSB_ST_TRIP = 2'b10,
    EFSB_ST_BLOCK = 2'b11
  } efsb_state_e;

  // Measurement values taken into events and records
  typedef struct packed {
    logic [15:0] i_pre20;
    logic [15:0] i_fault;
    logic [15:0] i_cap;
    logic [15:0] i_res;
    logic [15:0] u0_pct;
    logic [15:0] u0_volt;
    logic [15:0] angle;
    logic [15:0] i_pre200;
    logic [20:0] trip_rem_ms;
    logic [2:0] setting_group;
    logic [1:0] grounding;
  } efsb_meas_s;

  typedef struct packed {
    logic [3:0] code;
    logic [31:0] stamp_ms;
    efsb_meas_s meas;
  } efsb_rec_s;

  typedef struct packed {
    logic [1:0] earth_fault_stage_tag;
    logic [3:0] code;
    logic on;
    logic [31:0] stamp_ms;
    efsb_meas_s meas;
  } efsb_evt_s;

  typedef struct packed {
    logic pickup;
    logic pickup_res;
    logic pickup_rea;
    logic delay_done;
  } efsb_stage_in_s;

  typedef struct packed {
    logic start;
    logic trip;
    logic blocked;
    logic timer_run;
    logic release_pulse;
    logic [1:0] condition;
  } efsb_stage_out_s;

endpackage

/* File: core/efsb_top.sv */
// Earth fault stage blocking, event generation and fault record logic
//
// The register offsets and the AHB-Lite register port were decided locally.
module efsb_top #(
  parameter int MS_CYCLES = efsb_pkg::EFSB_MS_CYCLES
) (
  input wire logic sys_clk, // 250 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response
  input wire logic cycle_tick, // Program cycle start pulse
  input wire logic ext_block, // Blocking matrix input, async
  input wire logic [12:0] harm_ratio, // 2nd harmonic ratio, 0.01 percent
  input wire efsb_pkg::efsb_stage_in_s [3:0] stage_in, // Per stage pick-up
  input wire efsb_pkg::efsb_meas_s meas, // Present process data
  output efsb_pkg::efsb_stage_out_s [3:0] stage_out, // Per stage status
  output logic evt_valid, // Event to main buffer
  output efsb_pkg::efsb_evt_s evt, // Event contents
  output logic blk_notify, // Display notification pulse
  output logic irq // Level interrupt
);
  import efsb_pkg::*;

  // ----------------------------------------------------------------
  // Synchroniser and time base
  // ----------------------------------------------------------------
  logic blk_meta_reg;
  logic blk_sync_reg;
  logic [17:0] ms_div_reg;
  logic [31:0] stamp_reg;

  // Two flops on the blocking matrix pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      blk_meta_reg <= 1'b0;
      blk_sync_reg <= 1'b0;
    end else begin
      blk_meta_reg <= ext_block;
      blk_sync_reg <= blk_meta_reg;
    end
  end

  // Millisecond time stamp
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ms_div_reg <= 18'h00000;
      stamp_reg <= 32'h00000000;
    end else if (ms_div_reg == 18'(MS_CYCLES - 1)) begin
      ms_div_reg <= 18'h00000;
      stamp_reg <= stamp_reg + 32'h00000001;
    end else begin
      ms_div_reg <= ms_div_reg + 18'h00001;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic inrush_en_reg;
  logic [12:0] limit_reg;
  logic [13:0] on_mask_reg;
  logic [13:0] off_mask_reg;
  logic [11:0] irq_en_reg;
  logic [11:0] irq_stat_reg;
  logic [1:0] sel_stage_reg;
  logic [3:0] sel_age_reg;
  logic aph_valid_reg;
  logic aph_write_reg;
  logic [7:0] aph_addr_reg;
  logic [31:0] hrdata_reg;
  logic wr_en;
  logic blk_now;

  // Stage block from dedicated input plus optional inrush
  assign blk_now = blk_sync_reg | (inrush_en_reg & (harm_ratio > limit_reg));

  // ----------------------------------------------------------------
  // Stage state machines
  // ----------------------------------------------------------------
  efsb_state_e state_reg [EFSB_NUM_STAGES];
  logic [1:0] pickup_sub_reg [EFSB_NUM_STAGES];
  logic [EFSB_NUM_EVT-1:0] lvl;
  logic [EFSB_NUM_EVT-1:0] lvl_prev_reg;
  logic [EFSB_NUM_STAGES-1:0] release_reg;

  genvar g;
  generate
    for (g = 0; g < EFSB_NUM_STAGES; g++) begin : g_stage
      // Evaluate once per program cycle with freshly sampled block
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          state_reg[g] <= EFSB_ST_NORMAL;
        end else if (cycle_tick) begin
          unique case (state_reg[g])
            EFSB_ST_NORMAL: begin
              if (stage_in[g].pickup && blk_now) begin
                state_reg[g] <= EFSB_ST_BLOCK;
              end else if (stage_in[g].pickup) begin
                state_reg[g] <= EFSB_ST_START;
              end
            end
            EFSB_ST_START: begin
              if (!stage_in[g].pickup) begin
                state_reg[g] <= EFSB_ST_NORMAL;
              end else if (blk_now) begin
                state_reg[g] <= EFSB_ST_BLOCK;
              end else if (stage_in[g].delay_done) begin
                state_reg[g] <= EFSB_ST_TRIP;
              end
            end
            EFSB_ST_TRIP: begin
              if (!stage_in[g].pickup) begin
                state_reg[g] <= EFSB_ST_NORMAL;
              end else if (blk_now) begin
                state_reg[g] <= EFSB_ST_BLOCK;
              end
            end
            EFSB_ST_BLOCK: begin
              if (!stage_in[g].pickup) begin
                state_reg[g] <= EFSB_ST_NORMAL;
              end
            end
          endcase
        end
      end

      // Release pulse and component pick-ups latched per cycle
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          release_reg[g] <= 1'b0;
          pickup_sub_reg[g] <= 2'b00;
        end else begin
          release_reg[g] <= cycle_tick && (state_reg[g] == EFSB_ST_START ||
                            state_reg[g] == EFSB_ST_TRIP) &&
                            (!stage_in[g].pickup || blk_now);
          if (cycle_tick) begin
            pickup_sub_reg[g] <= {stage_in[g].pickup_rea, stage_in[g].pickup_res};
          end
        end
      end

      // Status levels: start, trip, blocked, res/rea start, res/rea trip
      assign lvl[g*EFSB_NUM_SIGS+0] = (state_reg[g] == EFSB_ST_START) ||
                                      (state_reg[g] == EFSB_ST_TRIP);
      assign lvl[g*EFSB_NUM_SIGS+1] = (state_reg[g] == EFSB_ST_TRIP);
      assign lvl[g*EFSB_NUM_SIGS+2] = (state_reg[g] == EFSB_ST_BLOCK);
      assign lvl[g*EFSB_NUM_SIGS+3] = lvl[g*EFSB_NUM_SIGS+0] & pickup_sub_reg[g][0];
      assign lvl[g*EFSB_NUM_SIGS+4] = lvl[g*EFSB_NUM_SIGS+0] & pickup_sub_reg[g][1];
      assign lvl[g*EFSB_NUM_SIGS+5] = lvl[g*EFSB_NUM_SIGS+1] & pickup_sub_reg[g][0];
      assign lvl[g*EFSB_NUM_SIGS+6] = lvl[g*EFSB_NUM_SIGS+1] & pickup_sub_reg[g][1];

      // Status outputs, condition code is the state code
      assign stage_out[g].start = lvl[g*EFSB_NUM_SIGS+0];
      assign stage_out[g].trip = lvl[g*EFSB_NUM_SIGS+1];
      assign stage_out[g].blocked = lvl[g*EFSB_NUM_SIGS+2];
      assign stage_out[g].timer_run = (state_reg[g] == EFSB_ST_START);
      assign stage_out[g].release_pulse = release_reg[g];
      assign stage_out[g].condition = state_reg[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Transition capture and event drain
  // ----------------------------------------------------------------
  logic [EFSB_NUM_EVT-1:0] pend_reg;
  logic [EFSB_NUM_EVT-1:0] pon_reg;
  logic [EFSB_NUM_EVT-1:0] chg;
  logic [EFSB_NUM_EVT-1:0] grant;
  logic found;
  logic [1:0] g_stage_idx;
  logic [2:0] g_sig_idx;
  logic g_on;
  logic [3:0] g_code;
  logic g_fwd;
  logic g_rec;

  assign chg = lvl ^ lvl_prev_reg;

  // Lowest pending transition goes first
  always_comb begin
    grant = '0;
    found = 1'b0;
    g_stage_idx = 2'b00;
    g_sig_idx = 3'b000;
    for (int s = 0; s < EFSB_NUM_STAGES; s++) begin
      for (int k = 0; k < EFSB_NUM_SIGS; k++) begin
        if (!found && pend_reg[s*EFSB_NUM_SIGS+k]) begin
          found = 1'b1;
          grant[s*EFSB_NUM_SIGS+k] = 1'b1;
          g_stage_idx = 2'(s);
          g_sig_idx = 3'(k);
        end
      end
    end
  end

  assign g_on = |(grant & pon_reg);
  assign g_code = {g_sig_idx, ~g_on};
  assign g_fwd = found && (g_on ? on_mask_reg[g_code] : off_mask_reg[g_code]);
  assign g_rec = found && g_on && (g_sig_idx < 3'h3);

  // New transitions win over the drain of the same bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lvl_prev_reg <= '0;
      pend_reg <= '0;
      pon_reg <= '0;
    end else begin
      lvl_prev_reg <= lvl;
      pend_reg <= (pend_reg & ~grant) | chg;
      pon_reg <= (pon_reg & ~chg) | (lvl & chg);
    end
  end

  // Event output with stamp and process data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evt_valid <= 1'b0;
      evt <= '0;
      blk_notify <= 1'b0;
    end else begin
      evt_valid <= g_fwd;
      blk_notify <= g_rec && (g_sig_idx == 3'h2);
      if (found) begin
        evt.earth_fault_stage_tag <= g_stage_idx;
        evt.code <= g_code;
        evt.on <= g_on;
        evt.stamp_ms <= stamp_reg;
        evt.meas <= meas;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault record rings
  // ----------------------------------------------------------------
  efsb_rec_s rec_mem [EFSB_NUM_STAGES*EFSB_REC_DEPTH];
  logic [3:0] wr_ptr_reg [EFSB_NUM_STAGES];
  logic [3:0] count_reg [EFSB_NUM_STAGES];
  logic [4:0] rd_slot;
  efsb_rec_s rd_rec;

  // Record write, ring wraps over the oldest entry
  always_ff @(posedge sys_clk) begin
    if (g_rec) begin
      rec_mem[6'(g_stage_idx * EFSB_REC_DEPTH) + 6'(wr_ptr_reg[g_stage_idx])] <=
        '{code: g_code, stamp_ms: stamp_reg, meas: meas};
    end
  end

  // Ring pointers and fill counts per stage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < EFSB_NUM_STAGES; s++) begin
        wr_ptr_reg[s] <= 4'h0;
        count_reg[s] <= 4'h0;
      end
    end else if (g_rec) begin
      if (wr_ptr_reg[g_stage_idx] == 4'(EFSB_REC_DEPTH - 1)) begin
        wr_ptr_reg[g_stage_idx] <= 4'h0;
      end else begin
        wr_ptr_reg[g_stage_idx] <= wr_ptr_reg[g_stage_idx] + 4'h1;
      end
      if (count_reg[g_stage_idx] != 4'(EFSB_REC_DEPTH)) begin
        count_reg[g_stage_idx] <= count_reg[g_stage_idx] + 4'h1;
      end
    end
  end

  // Slot of the selected age, 0 is newest
  always_comb begin
    rd_slot = 5'(wr_ptr_reg[sel_stage_reg]) + 5'(EFSB_REC_DEPTH - 1) - 5'(sel_age_reg);
    if (rd_slot >= 5'(EFSB_REC_DEPTH)) begin
      rd_slot = rd_slot - 5'(EFSB_REC_DEPTH);
    end
  end
  assign rd_rec = rec_mem[6'(sel_stage_reg * EFSB_REC_DEPTH) + 6'(rd_slot)];

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [11:0] irq_set;
  logic [11:0] irq_clr;

  // One sticky bit per stage for start, trip, blocked ON
  always_comb begin
    irq_set = 12'h000;
    if (g_rec) begin
      irq_set[4'(g_stage_idx * 3) + 4'(g_sig_idx)] = 1'b1;
    end
  end
  assign irq_clr = (wr_en && aph_addr_reg == EFSB_OFS_IRQ_CLR) ? hwdata[11:0] : 12'h000;

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= 12'h000;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic [7:0] cond_bits;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign wr_en = aph_valid_reg & aph_write_reg;
  assign cond_bits = {state_reg[3], state_reg[2], state_reg[1], state_reg[0]};

  // Address phase capture
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aph_valid_reg <= 1'b0;
      aph_write_reg <= 1'b0;
      aph_addr_reg <= 8'h00;
    end else if (hready) begin
      aph_valid_reg <= hsel & htrans[1];
      aph_write_reg <= hwrite;
      aph_addr_reg <= {haddr[7:2], 2'b00};
    end
  end

  // Read mux, unmapped and write-only offsets read zero
  always_comb begin
    rd_val = 32'h00000000;
    unique case ({haddr[7:2], 2'b00})
      EFSB_OFS_CTRL: rd_val[0] = inrush_en_reg;
      EFSB_OFS_LIMIT: rd_val[12:0] = limit_reg;
      EFSB_OFS_EVMASK: rd_val = {2'b00, off_mask_reg, 2'b00, on_mask_reg};
      EFSB_OFS_COND: rd_val[EFSB_COND_BLK_POS:0] = {blk_sync_reg, cond_bits};
      EFSB_OFS_IRQ_STAT: rd_val[11:0] = irq_stat_reg;
      EFSB_OFS_IRQ_EN: rd_val[11:0] = irq_en_reg;
      EFSB_OFS_REC_SEL: rd_val = {12'h000, count_reg[sel_stage_reg], 4'h0,
                                  sel_age_reg, 6'h00, sel_stage_reg};
      EFSB_OFS_REC_DATA + 8'h00: rd_val = {11'h000, rd_rec.meas.trip_rem_ms};
      EFSB_OFS_REC_DATA + 8'h04: rd_val = rd_rec.stamp_ms;
      EFSB_OFS_REC_DATA + 8'h08: rd_val = {rd_rec.meas.i_pre20, rd_rec.meas.i_fault};
      EFSB_OFS_REC_DATA + 8'h0C: rd_val = {rd_rec.meas.i_cap, rd_rec.meas.i_res};
      EFSB_OFS_REC_DATA + 8'h10: rd_val = {rd_rec.meas.u0_pct, rd_rec.meas.u0_volt};
      EFSB_OFS_REC_DATA + 8'h14: rd_val = {rd_rec.meas.angle, rd_rec.meas.i_pre200};
      EFSB_OFS_REC_DATA + 8'h18: rd_val = {20'h00000, rd_rec.meas.grounding,
                                           rd_rec.meas.setting_group, 3'b000, rd_rec.code};
      default: rd_val = 32'h00000000;
    endcase
  end

  // Read data registered at the address phase
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrdata_reg <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata_reg <= rd_val;
    end
  end

  // Register writes in the data phase
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inrush_en_reg <= EFSB_INRUSH_EN_RST;
      limit_reg <= EFSB_LIMIT_RST;
      on_mask_reg <= EFSB_EVMASK_RST;
      off_mask_reg <= EFSB_EVMASK_RST;
      irq_en_reg <= EFSB_IRQ_EN_RST;
      sel_stage_reg <= 2'b00;
      sel_age_reg <= 4'h0;
    end else if (wr_en) begin
      unique case (aph_addr_reg)
        EFSB_OFS_CTRL: inrush_en_reg <= hwdata[0];
        EFSB_OFS_LIMIT: limit_reg <= (hwdata[12:0] > EFSB_LIMIT_MAX) ?
                                     EFSB_LIMIT_MAX : hwdata[12:0];
        EFSB_OFS_EVMASK: begin
          on_mask_reg <= hwdata[13:0];
          off_mask_reg <= hwdata[EFSB_EVMASK_OFF_POS +: 14];
        end
        EFSB_OFS_IRQ_EN: irq_en_reg <= hwdata[11:0];
        EFSB_OFS_REC_SEL: begin
          sel_stage_reg <= hwdata[1:0];
          sel_age_reg <= (hwdata[EFSB_SEL_AGE_POS +: 4] > 4'(EFSB_REC_DEPTH - 1)) ?
                         4'(EFSB_REC_DEPTH - 1) : hwdata[EFSB_SEL_AGE_POS +: 4];
        end
        default: ;
      endcase
    end
  end

endmodule

/* File: verification/efsb_checker.sv */
// Concurrent checks on the stage status, event and bus outputs
module efsb_checker (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Slave response
  input wire logic cycle_tick, // Program cycle pulse
  input wire efsb_pkg::efsb_stage_out_s [3:0] stage_out, // Stage status
  input wire logic evt_valid, // Event strobe
  input wire efsb_pkg::efsb_evt_s evt, // Event contents
  input wire logic blk_notify // Notify pulse
);
  import efsb_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Status may only move one or two edges after a program cycle tick
  sequence s_recent_tick;
    $past(cycle_tick) || $past(cycle_tick, 2);
  endsequence
  // Start dropped because blocking took over
  sequence s_drop_to_block;
    $fell(stage_out[0].start) && stage_out[0].blocked;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_start_on_tick: assert property ($rose(stage_out[0].start) |-> s_recent_tick)
    else $error("start rose away from a tick");
  a_trip_after_start: assert property ($rose(stage_out[0].trip) |-> $past(stage_out[0].start))
    else $error("trip without prior start");
  a_block_no_start: assert property (stage_out[0].blocked |-> !stage_out[0].start && !stage_out[0].trip)
    else $error("blocked stage still starting");
  a_cond_code: assert property (stage_out[0].condition == (stage_out[0].blocked ? 2'd3 :
    stage_out[0].trip ? 2'd2 : stage_out[0].start ? 2'd1 : 2'd0))
    else $error("condition code wrong");
  a_release_on_block: assert property (s_drop_to_block |->
    (stage_out[0].release_pulse || $past(stage_out[0].release_pulse)) or ##1 stage_out[0].release_pulse)
    else $error("no release after block");
  a_notify_block: assert property ($rose(stage_out[0].blocked) |-> $past(blk_notify) or ##[0:3] blk_notify)
    else $error("no notification on block");
  a_evt_code: assert property (evt_valid |-> evt.code <= 4'hD)
    else $error("event code out of range");
  a_evt_polarity: assert property (evt_valid |-> evt.on == !evt.code[0])
    else $error("event polarity wrong");
endmodule

bind efsb_top efsb_checker i_chk (.sys_clk(sys_clk), .rst(rst), .hreadyout(hreadyout),
  .hresp(hresp), .cycle_tick(cycle_tick), .stage_out(stage_out), .evt_valid(evt_valid),
  .evt(evt), .blk_notify(blk_notify));

/* File: verification/efsb_partner.sv */
// Blocking matrix source and main event buffer sink
module efsb_partner (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic blk_req, // Block request from bench
  input wire logic evt_valid, // Event strobe
  input wire efsb_pkg::efsb_evt_s evt, // Event contents
  output logic ext_block, // Block line to stage
  output int n_evt, // Events buffered
  output logic [5:0] last_id // Last stage tag and code
);
  import efsb_pkg::*;
  // Block follows request one clock later, far ahead of any delay end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) ext_block <= 1'b0;
    else ext_block <= blk_req;
  end
  // Buffer keeps count and latest identity
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      n_evt <= 0;
      last_id <= 6'h00;
    end else if (evt_valid) begin
      n_evt <= n_evt + 1;
      last_id <= {evt.earth_fault_stage_tag, evt.code};
    end
  end
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the earth fault stage block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import efsb_pkg::*;
  typedef struct {int s; logic b; logic dd; logic [1:0] c;} efsb_row_s;
  efsb_row_s rows[4] = '{'{0, 0, 0, 1}, '{1, 1, 0, 3}, '{2, 0, 1, 2}, '{3, 1, 1, 3}};
  logic [39:0] regs[5] = '{40'h0000000000, 40'h0400000001, 40'h083FFF3FFF, 40'h1800000000,
    40'h4000000000};
  logic [31:0] lim[2] = '{32'h000000C7, 32'h000000C8};
  logic sys_clk, rst, hsel, hwrite, cycle_tick, blk_req, hreadyout, hresp;
  logic ext_block, evt_valid, blk_notify, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [12:0] harm_ratio;
  logic [5:0] last_id;
  efsb_stage_in_s [3:0] stage_in;
  efsb_meas_s meas;
  efsb_stage_out_s [3:0] stage_out;
  efsb_evt_s evt;
  int n_evt, n0, fail_count, checks_done;

  efsb_top #(.MS_CYCLES(10)) i_dut (.hready(hreadyout), .*);
  efsb_partner i_partner (.*);

  // Clock of 4 ns
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Next edge with ready high, bounded
  task automatic rdy();
    int n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      if (++n > 50) begin
        fail_count++;
        summarize();
      end
      @(posedge sys_clk);
    end
  endtask
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  // Settle inputs, pulse program cycle, let events drain
  task automatic tick();
    repeat (4) @(posedge sys_clk);
    cycle_tick <= 1'b1;
    @(posedge sys_clk);
    cycle_tick <= 1'b0;
    repeat (40) @(posedge sys_clk);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    {hsel, hwrite, cycle_tick, blk_req, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    harm_ratio = 13'h00C8;
    stage_in = '0;
    meas = '0;
    meas.setting_group = 3'h5;
    meas.grounding = 2'h2;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (regs[i]) begin
      bus(0, regs[i][39:32], 0);
      chk("reset value", regs[i][31:0], rd);
    end
    foreach (rows[i]) begin
      blk_req <= rows[i].b;
      stage_in[rows[i].s].pickup <= 1'b1;
      tick();
      stage_in[rows[i].s].delay_done <= rows[i].dd;
      tick();
      chk("condition", rows[i].c, stage_out[rows[i].s].condition);
      chk("timer run", rows[i].c == 2'h1, stage_out[rows[i].s].timer_run);
      bus(0, EFSB_OFS_COND, 0);
      chk("cond field", rows[i].c, rd[2*rows[i].s +: 2]);
      stage_in <= '0;
      blk_req <= 1'b0;
      tick();
    end
    bus(1, EFSB_OFS_REC_SEL, 0);
    bus(0, EFSB_OFS_REC_SEL, 0);
    chk("record count", 1, rd[19:16]);
    bus(1, EFSB_OFS_IRQ_CLR, 32'h00000FFF);
    bus(1, EFSB_OFS_IRQ_EN, 32'h00000040);
    n0 = n_evt;
    stage_in[2].pickup <= 1'b1;
    stage_in[2].pickup_res <= 1'b1;
    tick();
    chk("event count", n0 + 2, n_evt);
    chk("last event", 6'h26, last_id);
    chk("event data", 32'h00000005, evt.meas.setting_group);
    chk("irq raised", 1, irq);
    bus(0, EFSB_OFS_IRQ_STAT, 0);
    chk("irq status", 32'h00000040, rd);
    bus(1, EFSB_OFS_IRQ_EN, 0);
    repeat (2) @(posedge sys_clk);
    chk("irq masked", 0, irq);
    bus(1, EFSB_OFS_IRQ_CLR, 32'h00000040);
    bus(1, EFSB_OFS_IRQ_EN, 32'h00000040);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 0, irq);
    bus(1, EFSB_OFS_EVMASK, 32'h3FFF3FFE);
    stage_in <= '0;
    tick();
    n0 = n_evt;
    stage_in[2].pickup <= 1'b1;
    stage_in[2].pickup_res <= 1'b1;
    tick();
    chk("masked events", n0 + 1, n_evt);
    stage_in <= '0;
    tick();
    bus(1, EFSB_OFS_EVMASK, 32'h3FFF3FFF);
    stage_in[0].pickup <= 1'b1;
    tick();
    n0 = n_evt;
    blk_req <= 1'b1;
    tick();
    chk("block after start", 3, stage_out[0].condition);
    chk("block events", n0 + 2, n_evt);
    chk("block event id", 6'h04, last_id);
    stage_in <= '0;
    blk_req <= 1'b0;
    tick();
    bus(1, EFSB_OFS_LIMIT, 32'h00001FFF);
    bus(0, EFSB_OFS_LIMIT, 0);
    chk("limit clamp", 32'h00001388, rd);
    bus(1, EFSB_OFS_CTRL, 1);
    foreach (lim[i]) begin
      bus(1, EFSB_OFS_LIMIT, lim[i]);
      stage_in[3].pickup <= 1'b1;
      tick();
      chk("inrush block", i ? 1 : 3, stage_out[3].condition);
      stage_in <= '0;
      tick();
    end
    bus(1, EFSB_OFS_CTRL, 0);
    for (int k = 0; k < 13; k++) begin
      blk_req <= (k == 12);
      stage_in[0].pickup <= 1'b1;
      tick();
      stage_in <= '0;
      blk_req <= 1'b0;
      tick();
    end
    bus(1, EFSB_OFS_REC_SEL, 0);
    bus(0, EFSB_OFS_REC_SEL, 0);
    chk("record fill", 12, rd[19:16]);
    bus(0, EFSB_OFS_REC_DATA + 8'h18, 0);
    chk("record word", 32'h00000A84, rd);
    summarize();
  end
endmodule
